// >>> design/pmc_pkg.sv
// Package for the packet mode controller: register map, field layouts,
// reset values, mode encodings and timing figures.
// Assumes a 50 MHz system clock and a 32-bit register port.
package pmc_pkg;

	// ----------------------------------------------------------------
	// Register map (word offsets on the register port)
	// ----------------------------------------------------------------
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_CHARS = 4'h1;
	localparam logic [3:0] A_TIMES = 4'h2;
	localparam logic [3:0] A_DISP = 4'h3;
	localparam logic [3:0] A_CMD = 4'h4;
	localparam logic [3:0] A_STATUS = 4'h5;

	// Command codes written to A_CMD
	localparam logic [7:0] CMD_CHAT = 8'h01;
	localparam logic [7:0] CMD_RAW = 8'h02;
	localparam logic [7:0] CMD_FACTORY = 8'h03;

	localparam logic [7:0] CHAR_CR = 8'h0d;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PMC_CMD, PMC_CHAT, PMC_RAW} pmc_mode_e;

	typedef struct packed {
		logic flush_include;
		logic early_state_switch;
		logic auto_data_state_select;
	} pmc_ctrl_s;

	typedef struct packed {
		logic [7:0] escape_char;
		logic [7:0] drop_line_char;
		logic [7:0] drop_packet_char;
		logic [7:0] flush_char;
	} pmc_chars_s;

	// Both times are counted in ticks
	typedef struct packed {
		logic [15:0] escape_guard_time;
		logic [15:0] raw_flush_interval;
	} pmc_times_s;

	typedef struct packed {
		logic status_msgs;
		logic keep_high_bit_chat;
		logic echo;
		logic line_wrap_width;
		logic auto_linefeed;
	} pmc_disp_s;

	typedef struct packed {
		pmc_ctrl_s ctrl;
		pmc_chars_s chars;
		pmc_times_s times;
		pmc_disp_s disp;
	} pmc_cfg_s;

	typedef struct packed {
		logic in_conn;
		logic conn_ack;
		logic connect;
		logic fail;
		logic disc;
	} pmc_link_s;

	typedef struct packed {
		pmc_mode_e mode;
		pmc_cfg_s cfg;
		logic load;
		logic linked;
		logic [23:0] brk_cnt;
		logic [15:0] div;
		logic [15:0] idle;
		logic [15:0] fl_cnt;
		logic [7:0] pend_n;
		logic multi;
		logic [1:0] esc_n;
		logic [1:0] rep;
		logic hold_v;
		logic [7:0] hold_d;
		logic tx_v;
		logic [7:0] tx_d;
		logic flush;
		logic drop;
		logic prompt;
		logic [31:0] rdata;
	} pmc_st_s;

	// ----------------------------------------------------------------
	// Factory defaults and timing
	// ----------------------------------------------------------------
	localparam pmc_cfg_s CFG_DEFAULT = '{
		ctrl: '{flush_include: 1'b1, early_state_switch: 1'b0, auto_data_state_select: 1'b0},
		chars: '{escape_char: 8'h03, drop_line_char: 8'h18, drop_packet_char: 8'h19,
			flush_char: CHAR_CR},
		times: '{escape_guard_time: 16'h0064, raw_flush_interval: 16'h000a},
		disp: 5'h17
	};

	localparam int CLK_NS = 20;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int BAUD = 9600;
	localparam int FRAME_NS = 10 * (1000000000 / BAUD);
	localparam int BREAK_NS = 2 * FRAME_NS;
	localparam int BREAK_CYC = (BREAK_NS + CLK_NS - 1) / CLK_NS;
	localparam int PACLEN = 128;

endpackage

// >>> design/pmc_ctrl.sv
// Packet mode controller: command, chat and raw states, packetising
// triggers, break detection and the timed triple escape.
// Assumes host bytes arrive already deserialised, one per strobe, and that
// rx_line is the synchronous level of the serial receive line.
`timescale 1ns/1ns
module pmc_ctrl
	import pmc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int BREAK_CYCLES = BREAK_CYC,
	parameter int PKT_LEN = PACLEN
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire pmc_cfg_s backup_cfg,
	input wire pmc_link_s link,
	input wire logic rx_line,
	input wire logic host_v,
	input wire logic [7:0] host_d,
	output logic host_rdy,
	output logic tx_v,
	output logic [7:0] tx_d,
	output logic pkt_flush,
	output logic pkt_drop,
	output logic prompt,
	output pmc_mode_e mode,
	output logic queue_hold,
	output pmc_disp_s disp
);

	pmc_st_s s;
	pmc_st_s n;
	logic take;
	logic tick;
	logic brk_evt;
	logic emit;
	logic [7:0] eb;
	logic nocr;
	logic esc_hit;
	pmc_chars_s ch;
	pmc_times_s tm;

	assign ch = s.cfg.chars;
	assign tm = s.cfg.times;
	assign nocr = (ch.flush_char != CHAR_CR);
	assign esc_hit = (ch.escape_char != 8'h00) && (host_d == ch.escape_char);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Escape replay stalls the host so the held byte keeps its place
	assign host_rdy = !(s.mode == PMC_RAW && (s.rep != 2'd0 || s.hold_v));
	assign take = host_v && host_rdy;
	assign rdata = s.rdata;
	assign tx_v = s.tx_v;
	assign tx_d = s.tx_d;
	assign pkt_flush = s.flush;
	assign pkt_drop = s.drop;
	assign prompt = s.prompt;
	assign mode = s.mode;
	assign queue_hold = (s.mode != PMC_CMD) && !s.linked;

	// Raw state masks the display features without touching stored settings
	always_comb begin
		disp = s.cfg.disp;
		if (s.mode == PMC_RAW) begin
			disp = '{status_msgs: 1'b0, keep_high_bit_chat: 1'b1, echo: 1'b0,
				line_wrap_width: 1'b0, auto_linefeed: 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		n.tx_v = 1'b0;
		n.flush = 1'b0;
		n.drop = 1'b0;
		n.prompt = 1'b0;
		n.rdata = '0;
		emit = 1'b0;
		eb = 8'h00;
		tick = 1'b0;

		// Fixed tick divider feeds both timers
		if (s.div == 16'(TICK_CYCLES - 1)) begin
			n.div = '0;
			tick = 1'b1;
		end else begin
			n.div = s.div + 16'h0001;
		end
		// Idle time since the last host byte, saturating
		if (take) begin
			n.idle = '0;
		end else if (tick && s.idle != 16'hffff) begin
			n.idle = s.idle + 16'h0001;
		end

		// Break: space held for two frames, reported once per hold
		if (rx_line) begin
			n.brk_cnt = '0;
		end else if (s.brk_cnt != 24'(BREAK_CYCLES)) begin
			n.brk_cnt = s.brk_cnt + 24'h000001;
		end
		brk_evt = !rx_line && (s.brk_cnt == 24'(BREAK_CYCLES - 1));

		// First cycle after power-up takes the backed-up settings
		if (s.load) begin
			n.cfg = backup_cfg;
			n.load = 1'b0;
		end

		// Register writes
		if (wr) begin
			case (addr)
				A_CTRL: n.cfg.ctrl = pmc_ctrl_s'(wdata[2:0]);
				A_CHARS: n.cfg.chars = pmc_chars_s'(wdata);
				A_TIMES: n.cfg.times = pmc_times_s'(wdata);
				A_DISP: n.cfg.disp = pmc_disp_s'(wdata[4:0]);
				A_CMD: begin
					case (wdata[7:0])
						CMD_CHAT: n.mode = PMC_CHAT;
						CMD_RAW: n.mode = PMC_RAW;
						CMD_FACTORY: n.cfg = CFG_DEFAULT;
						default: ;
					endcase
				end
				default: ;
			endcase
		end
		// Register reads; unmapped offsets answer zero
		if (rd) begin
			case (addr)
				A_CTRL: n.rdata = {29'h0, s.cfg.ctrl};
				A_CHARS: n.rdata = s.cfg.chars;
				A_TIMES: n.rdata = s.cfg.times;
				A_DISP: n.rdata = {27'h0, s.cfg.disp};
				A_STATUS: n.rdata = {26'h0, s.esc_n,
					s.brk_cnt == 24'(BREAK_CYCLES), s.linked, s.mode};
				default: n.rdata = '0;
			endcase
		end

		// Link events
		if (link.in_conn || link.conn_ack) begin
			n.linked = 1'b1;
		end
		if (link.fail || link.disc) begin
			n.linked = 1'b0;
		end
		if (s.mode == PMC_CMD) begin
			// Early switch enters before the link exists; input is queued
			if (link.connect && s.cfg.ctrl.early_state_switch) begin
				n.mode = s.cfg.ctrl.auto_data_state_select ? PMC_RAW : PMC_CHAT;
			end
			// Connection complete: incoming acknowledged or remote ack
			if (link.in_conn || link.conn_ack) begin
				n.mode = s.cfg.ctrl.auto_data_state_select ? PMC_RAW : PMC_CHAT;
			end
		end

		// Host bytes by state
		case (s.mode)
			PMC_CMD: begin
				if (take && host_d == CHAR_CR) begin
					n.prompt = 1'b1;
				end
			end
			PMC_CHAT: begin
				if (take) begin
					if (esc_hit) begin
						n.mode = PMC_CMD;
					end else if (ch.flush_char != 8'h00 && host_d == ch.flush_char) begin
						emit = s.cfg.ctrl.flush_include;
						eb = host_d;
						n.flush = 1'b1;
					end else if (nocr && ch.drop_packet_char != 8'h00
						&& host_d == ch.drop_packet_char) begin
						n.drop = 1'b1;
					end else if (nocr && !s.multi && ch.drop_line_char != 8'h00
						&& host_d == ch.drop_line_char) begin
						n.drop = 1'b1;
					end else begin
						emit = 1'b1;
						eb = s.cfg.disp.keep_high_bit_chat ? host_d : {1'b0, host_d[6:0]};
						if (nocr && host_d == CHAR_CR) begin
							n.multi = 1'b1;
						end
					end
				end
			end
			PMC_RAW: begin
				// Replay held escapes first, then the byte that aborted them
				if (s.rep != 2'd0) begin
					emit = 1'b1;
					eb = ch.escape_char;
					n.rep = s.rep - 2'd1;
				end else if (s.hold_v) begin
					emit = 1'b1;
					eb = s.hold_d;
					n.hold_v = 1'b0;
				end else if (take) begin
					if (tm.escape_guard_time == 16'h0000 || ch.escape_char == 8'h00) begin
						emit = 1'b1;
						eb = host_d;
					end else begin
						case (s.esc_n)
							2'd0: begin
								if (esc_hit && s.idle >= tm.escape_guard_time) begin
									n.esc_n = 2'd1;
								end else begin
									emit = 1'b1;
									eb = host_d;
								end
							end
							2'd3: begin
								n.rep = s.esc_n;
								n.esc_n = 2'd0;
								n.hold_v = 1'b1;
								n.hold_d = host_d;
							end
							default: begin
								if (esc_hit && s.idle < tm.escape_guard_time) begin
									n.esc_n = s.esc_n + 2'd1;
								end else begin
									n.rep = s.esc_n;
									n.esc_n = 2'd0;
									n.hold_v = 1'b1;
									n.hold_d = host_d;
								end
							end
						endcase
					end
				end else if (s.esc_n != 2'd0 && s.idle >= tm.escape_guard_time) begin
					// Guard ran out: complete after three, else give escapes back
					if (s.esc_n == 2'd3) begin
						n.mode = PMC_CMD;
					end else begin
						n.rep = s.esc_n;
						n.esc_n = 2'd0;
					end
				end
				// Interval flush timer runs only while data waits
				if (s.pend_n != 8'h00) begin
					if (tick) begin
						n.fl_cnt = s.fl_cnt + 16'h0001;
					end
					if (tm.raw_flush_interval != 16'h0000
						&& s.fl_cnt >= tm.raw_flush_interval) begin
						n.flush = 1'b1;
					end
				end
			end
			default: n.mode = PMC_CMD;
		endcase

		// Byte into the packet; a full packet goes out at once
		if (emit) begin
			n.tx_v = 1'b1;
			n.tx_d = eb;
			n.pend_n = s.pend_n + 8'h01;
			if (s.pend_n == 8'(PKT_LEN - 1)) begin
				n.flush = 1'b1;
			end
		end
		if (n.flush || n.drop) begin
			n.pend_n = '0;
			n.multi = 1'b0;
			n.fl_cnt = '0;
		end

		// Exits that override everything else
		if (link.fail && !s.linked && s.mode != PMC_CMD) begin
			n.mode = PMC_CMD;
		end
		if (link.disc) begin
			n.mode = PMC_CMD;
		end
		if (brk_evt) begin
			n.mode = PMC_CMD;
		end

		// Any state change or break drops escape progress; command entry prompts
		if (n.mode != s.mode || brk_evt) begin
			n.esc_n = 2'd0;
			n.rep = 2'd0;
			n.hold_v = 1'b0;
			if (n.mode == PMC_CMD) begin
				n.prompt = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset takes constants only; backup settings load one cycle later
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
			s.mode <= PMC_CMD;
			s.cfg <= CFG_DEFAULT;
			s.load <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_reset_cmd;
		@(posedge clk) !rstn |=> (s.mode == PMC_CMD);
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("not in command after reset");

	property p_break_exit;
		@(posedge clk) disable iff (!rstn)
		(!rx_line && s.brk_cnt == 24'(BREAK_CYCLES - 1)) |=> (s.mode == PMC_CMD) && prompt;
	endproperty
	a_break_exit: assert property (p_break_exit) else $error("break did not exit");

	property p_disc;
		@(posedge clk) disable iff (!rstn)
		(link.disc && s.mode != PMC_CMD) |=> (s.mode == PMC_CMD) && !queue_hold;
	endproperty
	a_disc: assert property (p_disc) else $error("disconnect kept data state");

	property p_chat_flush;
		@(posedge clk) disable iff (!rstn)
		(s.mode == PMC_CHAT && take && ch.flush_char != 8'h00 && host_d == ch.flush_char
			&& !esc_hit && !link.disc) |=> pkt_flush && (s.pend_n == 8'h00);
	endproperty
	a_chat_flush: assert property (p_chat_flush) else $error("flush char missed");

	property p_incl;
		@(posedge clk) disable iff (!rstn)
		(s.mode == PMC_CHAT && take && host_d == ch.flush_char && ch.flush_char != 8'h00
			&& !esc_hit && s.cfg.ctrl.flush_include) |=> tx_v && (tx_d == $past(host_d));
	endproperty
	a_incl: assert property (p_incl) else $error("flush char not included");

	property p_raw_fwd;
		@(posedge clk) disable iff (!rstn)
		(s.mode == PMC_RAW && take && tm.escape_guard_time == 16'h0000)
			|=> tx_v && (tx_d == $past(host_d));
	endproperty
	a_raw_fwd: assert property (p_raw_fwd) else $error("raw byte altered");

	property p_raw_esc;
		@(posedge clk) disable iff (!rstn)
		(s.mode == PMC_RAW && s.esc_n == 2'd3 && !take && s.idle >= tm.escape_guard_time)
			|=> (s.mode == PMC_CMD) && prompt;
	endproperty
	a_raw_esc: assert property (p_raw_esc) else $error("escape did not complete");

	property p_abort;
		@(posedge clk) disable iff (!rstn)
		(s.mode == PMC_RAW && s.esc_n == 2'd3 && take && !link.disc && !brk_evt)
			|=> !host_rdy ##1 (tx_v && tx_d == ch.escape_char);
	endproperty
	a_abort: assert property (p_abort) else $error("escape abort lost data");

	property p_early;
		@(posedge clk) disable iff (!rstn)
		(s.mode == PMC_CMD && link.connect && s.cfg.ctrl.early_state_switch && !link.disc
			&& !link.fail && !brk_evt && !s.load && !s.linked) |=> (s.mode != PMC_CMD) && queue_hold;
	endproperty
	a_early: assert property (p_early) else $error("early switch ignored");

	property p_cmd_chat;
		@(posedge clk) disable iff (!rstn)
		(wr && addr == A_CMD && wdata[7:0] == CMD_CHAT && !link.disc && !link.fail && !brk_evt
			&& !(s.mode == PMC_RAW && s.esc_n == 2'd3)) |=> (s.mode == PMC_CHAT);
	endproperty
	a_cmd_chat: assert property (p_cmd_chat) else $error("chat command ignored");

endmodule // pmc_ctrl

// >>> testbench/pmc_host.sv
// Host terminal model for the packet mode controller bench.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ns
module pmc_host (
	input wire logic clk,
	input wire logic host_rdy,
	output logic host_v,
	output logic [7:0] host_d,
	output logic rx_line
);
	int hangs;

	// ---------------------------------------------------------------
	// Idle levels
	// ---------------------------------------------------------------
	initial begin
		host_v = 1'b0;
		host_d = 8'h00;
		rx_line = 1'b1;
		hangs = 0;
	end

	// Byte stays offered until the controller takes it; a stall is counted
	task automatic send(input logic [7:0] b);
		int i;
		host_v <= 1'b1;
		host_d <= b;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (host_rdy === 1'b1) break;
		end
		if (i == 100) hangs++;
	endtask

	// Released data line shows the inverse so a stale byte never looks valid
	task automatic done();
		host_v <= 1'b0;
		host_d <= ~host_d;
	endtask

	// Line held at space past the two-frame break time
	task automatic brk(input int n);
		rx_line <= 1'b0;
		repeat (n) @(posedge clk);
		rx_line <= 1'b1;
	endtask
endmodule // pmc_host

// >>> testbench/pmc_ctrl_tb.sv
// Self-checking bench for pmc_ctrl: expected events go into a queue,
// a monitor pops them in order as the outputs pulse.
// Assumes pmc_pkg and pmc_host are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module pmc_ctrl_tb;
	import pmc_pkg::*;
	localparam int PKT = 8;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	pmc_cfg_s bk;
	pmc_link_s link = '0;
	logic rx_line, host_v, host_rdy, tx_v, pkt_flush, pkt_drop, prompt, queue_hold;
	logic [7:0] host_d, tx_d, b;
	pmc_mode_e mode, prev_mode;
	pmc_disp_s disp;
	logic [35:0] exp_q[$];
	logic [35:0] e;
	logic rd_q, watch_prompt;
	int n_errors = 0;
	int comparisons = 0;
	int i;

	always #10 clk = ~clk;

	pmc_ctrl #(.TICK_CYCLES(4), .BREAK_CYCLES(16), .PKT_LEN(PKT)) dut (.clk(clk), .rstn(rstn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .backup_cfg(bk),
		.link(link), .rx_line(rx_line), .host_v(host_v), .host_d(host_d), .host_rdy(host_rdy),
		.tx_v(tx_v), .tx_d(tx_d), .pkt_flush(pkt_flush), .pkt_drop(pkt_drop), .prompt(prompt),
		.mode(mode), .queue_hold(queue_hold), .disp(disp));

	pmc_host host (.clk(clk), .host_rdy(host_rdy), .host_v(host_v), .host_d(host_d),
		.rx_line(rx_line));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic ex(input logic [3:0] k, input logic [31:0] d);
		exp_q.push_back({k, d});
	endtask

	task automatic got(input logic [35:0] v);
		if (exp_q.size() == 0) begin
			n_errors++;
			$display("CHECK FAILED t=%0t unexpected event %h", $time, v);
		end else begin
			e = exp_q.pop_front();
			`CHK(v, e)
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [31:0] d);
		ex(4'h6, d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pulse(input pmc_link_s v);
		link <= v;
		@(posedge clk);
		link <= '0;
		@(posedge clk);
	endtask

	// Bounded wait for every noted event to show up, then a quiet spell
	task automatic drain();
		for (int k = 0; k < 400 && exp_q.size() != 0; k++) @(posedge clk);
		// A stalled host byte ends the run here as well
		if (exp_q.size() != 0 || host.hangs != 0) begin
			n_errors++;
			$display("CHECK FAILED t=%0t expected events missing or host stalled", $time);
			wrap_up();
		end else begin
			repeat (30) @(posedge clk);
		end
	endtask

	task automatic tx(input logic [7:0] d);
		ex(4'h2, {24'h0, d});
		host.send(d);
	endtask

	task automatic wrap_up();
		if (host.hangs != 0) n_errors++;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Monitor: fixed order within a cycle, same as the notes are pushed
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (rstn) begin
			if (mode !== prev_mode) begin
				got({4'h1, 30'h0, mode});
				prev_mode = mode;
			end
			if (tx_v === 1'b1) got({4'h2, 24'h0, tx_d});
			if (pkt_flush === 1'b1) got({4'h3, 32'h0});
			if (pkt_drop === 1'b1) got({4'h4, 32'h0});
			if (prompt === 1'b1 && watch_prompt) got({4'h5, 32'h0});
			if (rd_q) got({4'h6, rdata});
			rd_q = rd;
		end else begin
			prev_mode = PMC_CMD;
			rd_q = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'ha53a));
		// Random backup chars, times and display settings, plus a changed auto select bit, prove the power-up load
		bk = CFG_DEFAULT;
		bk.ctrl.auto_data_state_select = 1'b1; // Differs from factory on purpose
		bk.chars = pmc_chars_s'($urandom);
		bk.times = pmc_times_s'($urandom);
		bk.disp = pmc_disp_s'(5'($urandom));
		watch_prompt = 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(mode, PMC_CMD)
		rd_reg(A_CTRL, 32'h5);
		rd_reg(A_CHARS, bk.chars);
		rd_reg(A_TIMES, bk.times);
		rd_reg(A_DISP, {27'h0, bk.disp});
		`CHK(disp, bk.disp)
		rd_reg(4'hf, 32'h0);
		watch_prompt = 1'b1;
		host.send(8'h41);
		ex(4'h5, 32'h0);
		host.send(CHAR_CR);
		host.done();
		drain();
		watch_prompt = 1'b0;
		// Link driven entries and exits
		ex(4'h1, {30'h0, PMC_RAW});
		pulse('{in_conn: 1'b1, default: 1'b0});
		drain();
		ex(4'h1, {30'h0, PMC_CMD});
		pulse('{disc: 1'b1, default: 1'b0});
		drain();
		wr_reg(A_CMD, {24'h0, CMD_FACTORY});
		rd_reg(A_CTRL, 32'h4);
		rd_reg(A_CHARS, 32'h0318190d);
		pulse('{connect: 1'b1, default: 1'b0});
		ex(4'h1, {30'h0, PMC_CHAT});
		pulse('{conn_ack: 1'b1, default: 1'b0});
		ex(4'h1, {30'h0, PMC_CMD});
		pulse('{disc: 1'b1, default: 1'b0});
		drain();
		wr_reg(A_CTRL, 32'h6);
		ex(4'h1, {30'h0, PMC_CHAT});
		pulse('{connect: 1'b1, default: 1'b0});
		`CHK(queue_hold, 1'b1)
		ex(4'h1, {30'h0, PMC_CMD});
		pulse('{fail: 1'b1, default: 1'b0});
		drain();
		// Chat: high bit cleared, flush char with and without include
		wr_reg(A_CTRL, 32'h4);
		ex(4'h1, {30'h0, PMC_CHAT});
		wr_reg(A_CMD, {24'h0, CMD_CHAT});
		ex(4'h2, 32'h41);
		host.send(8'hc1);
		tx(CHAR_CR);
		ex(4'h3, 32'h0);
		host.done();
		drain();
		wr_reg(A_CTRL, 32'h0);
		ex(4'h3, 32'h0);
		host.send(CHAR_CR);
		for (i = 0; i < PKT; i++) tx(8'h61 + i[7:0]);
		ex(4'h3, 32'h0);
		host.done();
		drain();
		// Drop characters with a non-CR flush char
		wr_reg(A_CHARS, 32'h0318193b);
		tx(8'h78);
		ex(4'h4, 32'h0);
		host.send(8'h18);
		tx(8'h79);
		tx(CHAR_CR);
		tx(8'h7a);
		ex(4'h4, 32'h0);
		host.send(8'h19);
		ex(4'h3, 32'h0);
		host.send(8'h3b);
		ex(4'h1, {30'h0, PMC_CMD});
		host.send(8'h03);
		host.done();
		drain();
		wr_reg(A_CHARS, 32'h0318190d);
		ex(4'h1, {30'h0, PMC_CHAT});
		wr_reg(A_CMD, {24'h0, CMD_CHAT});
		drain();
		watch_prompt = 1'b1;
		ex(4'h1, {30'h0, PMC_CMD});
		ex(4'h5, 32'h0);
		host.brk(24);
		drain();
		// Raw: everything forwarded, interval and full-packet flush
		wr_reg(A_TIMES, 32'h00030005);
		ex(4'h1, {30'h0, PMC_RAW});
		wr_reg(A_CMD, {24'h0, CMD_RAW});
		drain();
		`CHK(disp, 5'h08)
		for (i = 0; i < 4; i++) begin
			b = 8'($urandom);
			if (b == 8'h03) b = 8'h04;
			tx(b);
		end
		tx(CHAR_CR);
		tx(8'h19);
		ex(4'h3, 32'h0);
		host.done();
		drain();
		for (i = 0; i < PKT; i++) tx(8'h80 + i[7:0]);
		ex(4'h3, 32'h0);
		host.done();
		drain();
		// Timed triple escape: guard idle on both sides, then three escapes aborted by a fourth byte and replayed
		for (i = 0; i < 3; i++) host.send(8'h03);
		host.done();
		ex(4'h1, {30'h0, PMC_CMD});
		ex(4'h5, 32'h0);
		drain();
		`CHK(disp, 5'h17)
		ex(4'h1, {30'h0, PMC_RAW});
		wr_reg(A_CMD, {24'h0, CMD_RAW});
		drain();
		for (i = 0; i < 3; i++) tx(8'h03);
		tx(8'h55);
		ex(4'h3, 32'h0);
		host.done();
		drain();
		// Zero guard: escapes are plain data, only break leaves
		wr_reg(A_TIMES, 32'h00000005);
		for (i = 0; i < 3; i++) tx(8'h03);
		ex(4'h3, 32'h0);
		host.done();
		drain();
		ex(4'h1, {30'h0, PMC_CMD});
		ex(4'h5, 32'h0);
		host.brk(24);
		drain();
		wrap_up();
	end
endmodule // pmc_ctrl_tb
